/* mii_rx_pkg.sv */
// constants, field layouts and carrier types for the second mii receive channel
// assumes a single system clock; no other package is needed
`default_nettype none

package mii_rx_pkg;

  // register offsets on the configuration port
  localparam logic [7:0]  RX_CFG2_OFFSET   = 8'h04;
  localparam logic [7:0]  TX_CFG1_OFFSET   = 8'h10;

  // reset values
  localparam logic [31:0] RX_CFG2_RESET    = 32'h0000_0008;
  localparam logic [31:0] TX_CFG1_RESET    = 32'h0002_0010;

  // receive configuration field positions
  localparam int          RXF_ENABLE       = 0;
  localparam int          RXF_STRIP        = 2;
  localparam int          RXF_PORT         = 3;
  localparam int          RXF_BUF          = 4;
  localparam int          RXF_SWAP         = 5;
  localparam int          RXF_FWD          = 6;
  localparam logic [31:0] RX_CFG_WMASK     = 32'h0000_007d;

  // transmit configuration field positions
  localparam int          TXF_ENABLE       = 0;
  localparam int          TXF_AUTOPRE      = 1;
  localparam int          TXF_ENMODE       = 2;
  localparam int          TXF_SWAP         = 3;
  localparam int          TXF_PORT         = 8;
  localparam int          TXF_AUTOSEQ      = 9;
  localparam int          TXF_START_LSB    = 16;
  localparam int          TXF_START_MSB    = 25;
  localparam int          TXF_CLKDLY_LSB   = 28;
  localparam int          TXF_CLKDLY_MSB   = 30;
  localparam logic [31:0] TX_CFG_WMASK     = 32'h73ff_030f;
  localparam logic [31:0] TX_CFG_RO_ONES   = 32'h0000_0010;

  // start frame delimiter nibble as it arrives on the wire
  localparam logic [3:0]  SFD_NIBBLE       = 4'hd;

  // buffer defaults
  localparam int          BUF_DEPTH_DEF    = 64;

  // frame tracking states
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_PREAMBLE = 2'b01,
    ST_DATA     = 2'b10
  } frame_state_type;

  // one mii receive port as it arrives on pins
  typedef struct packed {
    logic       rx_clk;
    logic       rx_dv;
    logic [3:0] rxd;
  } mii_pins_type;

  // word handed to the core input register and the receive buffer
  typedef struct packed {
    logic [15:0] data;
    logic        two_bytes;
  } rx_word_type;

  // preamble nibble handed to the transmit level-1 fifo
  typedef struct packed {
    logic [3:0] nibble;
    logic       sfd;
  } fwd_nibble_type;

  // transmit configuration fields for the transmit side
  typedef struct packed {
    logic [2:0] clk_delay;
    logic [9:0] start_delay;
    logic       auto_sequence;
    logic       transmit_port_select;
    logic       byte_swap;
    logic       en_mode;
    logic       auto_preamble;
    logic       enable;
  } tx_cfg_type;

endpackage : mii_rx_pkg

`default_nettype wire

/* pin_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to clk; output follows once stages two and three agree
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // asynchronous pins
  input  wire logic [WIDTH-1:0] async_in,
  // filtered level
  output var  logic [WIDTH-1:0] stable_out
);

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync: WIDTH must be at least 1");
    end
  end

  // one chain per bit; stage one feeds only stage two
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic out_r;

    always_ff @(posedge clk) begin
      if (srst) begin
        s1_r  <= 1'b0;
        s2_r  <= 1'b0;
        s3_r  <= 1'b0;
        out_r <= 1'b0;
      end else begin
        s1_r <= async_in[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        // a change counts only once two samples agree
        if (s2_r == s3_r) begin
          out_r <= s3_r;
        end
      end
    end

    assign stable_out[i] = out_r;
  end

endmodule : pin_sync

`default_nettype wire

/* mii_receive_port_config.sv */
// second mii receive channel: configuration registers, port select, preamble handling,
// nibble-to-word assembly, level-2 receive buffer and preamble forwarding
// assumes mii pins are asynchronous and the phy nibble clock is well below clk/6
// How it works
// - with preamble forwarding on, every preamble nibble up to and including the sfd goes to the transmit fifo.
// - forwarding accepts an odd nibble count before the sfd, and the first delivered byte is the destination address.
// - without swap byte1 sits in [15:8] and byte0 in [7:0], swap exchanges them, nibble0 comes first.
// - the buffer enable feeds the buffer with receive words, and when clear the buffer is scratch store.
// - port select picks mii port 0 or 1 and resets to port 1.
// - with stripping and forwarding both clear every nibble but a lone trailing one, preamble included, reaches the core register.
// - with stripping set preamble and sfd are dropped so the destination address comes first.
// - the enable bit blocks or passes traffic from the selected port.
// - the receive configuration sits at 4h, resets to 8h, and reserved bits read zero.
// - the transmit configuration sits at 10h, resets to 00020010h with its documented field layout.
`default_nettype none

module mii_receive_port_config
  import mii_rx_pkg::*;
#(
  parameter int BUF_DEPTH = BUF_DEPTH_DEF,
  parameter int BUF_AW    = $clog2(BUF_DEPTH)
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // configuration register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [31:0]       reg_wdata,
  output var  logic [31:0]       reg_rdata,
  // mii receive pins
  input  wire mii_pins_type      mii_port0,
  input  wire mii_pins_type      mii_port1,
  // core input register feed
  output var  rx_word_type       core_input_register,
  output var  logic              core_word_valid,
  output var  logic              frame_end,
  output var  logic              frame_active,
  // transmit level-1 fifo feed
  output var  fwd_nibble_type    transmit_level1_fifo,
  output var  logic              fwd_valid,
  // receive level-2 buffer scratch port
  input  wire logic [BUF_AW-1:0] buf_addr,
  input  wire logic              buf_wr,
  input  wire logic [15:0]       buf_wdata,
  output var  logic [15:0]       buf_rdata,
  output var  logic [BUF_AW:0]   buf_fill,
  // transmit configuration fields
  output var  tx_cfg_type        transmit_config
);

  initial begin
    if (BUF_DEPTH < 2 || BUF_DEPTH != (1 << BUF_AW)) begin
      $error("mii_receive_port_config: BUF_DEPTH must be a power of two of at least 2");
    end
  end

  logic [31:0]     receive_config_second_r;
  logic [31:0]     transmit_config_first_r;
  logic [31:0]     reg_rdata_r;
  mii_pins_type    port0_s;
  mii_pins_type    port1_s;
  mii_pins_type    sel_s;
  logic            rx_clk_d_r;
  logic            nib_stb;
  logic            rx_enable;
  logic            preamble_strip;
  logic            preamble_forward_en;
  logic            receive_buffer_en;
  logic            byte_swap;
  logic            receive_port_select;
  frame_state_type state_r;
  frame_state_type state_nxt;
  logic            data_nib;
  logic            fwd_nib;
  logic            end_stb;
  logic [1:0]      nib_cnt_r;
  logic [15:0]     acc_r;
  rx_word_type     word_r;
  logic            word_valid_r;
  logic            frame_end_r;
  fwd_nibble_type  fwd_r;
  logic            fwd_valid_r;
  logic [15:0]     buf_mem [BUF_DEPTH];
  logic [BUF_AW:0] wr_ptr_r;
  logic [15:0]     buf_rdata_r;

  // config fields
  assign rx_enable           = receive_config_second_r[RXF_ENABLE];
  assign preamble_strip      = receive_config_second_r[RXF_STRIP];
  assign receive_port_select = receive_config_second_r[RXF_PORT];
  assign receive_buffer_en   = receive_config_second_r[RXF_BUF];
  assign byte_swap           = receive_config_second_r[RXF_SWAP];
  assign preamble_forward_en = receive_config_second_r[RXF_FWD];

  // register writes; only writable bits store, reserved bits stay at their fixed values
  always_ff @(posedge clk) begin
    if (srst) begin
      receive_config_second_r <= RX_CFG2_RESET;
      transmit_config_first_r <= TX_CFG1_RESET;
    end else if (reg_wr) begin
      if (reg_addr == RX_CFG2_OFFSET) begin
        receive_config_second_r <= reg_wdata & RX_CFG_WMASK;
      end else if (reg_addr == TX_CFG1_OFFSET) begin
        transmit_config_first_r <= (reg_wdata & TX_CFG_WMASK) | TX_CFG_RO_ONES;
      end
    end
  end

  // register reads, one cycle after the address; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata_r <= 32'h0000_0000;
    end else if (reg_addr == RX_CFG2_OFFSET) begin
      reg_rdata_r <= receive_config_second_r;
    end else if (reg_addr == TX_CFG1_OFFSET) begin
      reg_rdata_r <= transmit_config_first_r;
    end else begin
      reg_rdata_r <= 32'h0000_0000;
    end
  end
  assign reg_rdata = reg_rdata_r;

  // transmit fields handed on; transmit behaviour lives elsewhere
  assign transmit_config.clk_delay            = transmit_config_first_r[TXF_CLKDLY_MSB:TXF_CLKDLY_LSB];
  assign transmit_config.start_delay          = transmit_config_first_r[TXF_START_MSB:TXF_START_LSB];
  assign transmit_config.auto_sequence        = transmit_config_first_r[TXF_AUTOSEQ];
  assign transmit_config.transmit_port_select = transmit_config_first_r[TXF_PORT];
  assign transmit_config.byte_swap            = transmit_config_first_r[TXF_SWAP];
  assign transmit_config.en_mode              = transmit_config_first_r[TXF_ENMODE];
  assign transmit_config.auto_preamble        = transmit_config_first_r[TXF_AUTOPRE];
  assign transmit_config.enable               = transmit_config_first_r[TXF_ENABLE];

  // pin synchronisers, one per port
  pin_sync #(
    .WIDTH      ($bits(mii_pins_type))
  ) u_sync0 (
    .clk        (clk),
    .srst       (srst),
    .async_in   (mii_port0),
    .stable_out (port0_s)
  );

  pin_sync #(
    .WIDTH      ($bits(mii_pins_type))
  ) u_sync1 (
    .clk        (clk),
    .srst       (srst),
    .async_in   (mii_port1),
    .stable_out (port1_s)
  );

  // port select and rising edge of the selected nibble clock
  assign sel_s = receive_port_select ? port1_s : port0_s;
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_clk_d_r <= 1'b0;
    end else begin
      rx_clk_d_r <= sel_s.rx_clk;
    end
  end
  // disabled port produces no nibbles at all
  assign nib_stb = sel_s.rx_clk & ~rx_clk_d_r & rx_enable;

  // nibble classification; a preamble is only hunted when stripping or forwarding
  always_comb begin
    state_nxt = state_r;
    data_nib  = 1'b0;
    fwd_nib   = 1'b0;
    end_stb   = 1'b0;
    if (!rx_enable) begin
      end_stb   = (state_r != ST_IDLE);
      state_nxt = ST_IDLE;
    end else if (nib_stb) begin
      case (state_r)
        ST_IDLE: begin
          if (sel_s.rx_dv) begin
            if (preamble_strip || preamble_forward_en) begin
              fwd_nib   = preamble_forward_en;
              state_nxt = (sel_s.rxd == SFD_NIBBLE) ? ST_DATA : ST_PREAMBLE;
            end else begin
              data_nib  = 1'b1;
              state_nxt = ST_DATA;
            end
          end
        end
        ST_PREAMBLE: begin
          if (!sel_s.rx_dv) begin
            end_stb   = 1'b1;
            state_nxt = ST_IDLE;
          end else begin
            fwd_nib = preamble_forward_en;
            // any nibble count up to the sfd is accepted
            if (sel_s.rxd == SFD_NIBBLE) begin
              state_nxt = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (!sel_s.rx_dv) begin
            end_stb   = 1'b1;
            state_nxt = ST_IDLE;
          end else begin
            data_nib = 1'b1;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // frame state
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign frame_active = (state_r != ST_IDLE);

  // nibble accumulation; nibble0 lands in the lowest bits
  always_ff @(posedge clk) begin
    if (srst) begin
      nib_cnt_r <= 2'd0;
      acc_r     <= 16'h0000;
    end else if (end_stb || state_r == ST_IDLE && !data_nib) begin
      nib_cnt_r <= 2'd0;
    end else if (data_nib) begin
      acc_r[4*nib_cnt_r +: 4] <= sel_s.rxd;
      nib_cnt_r               <= nib_cnt_r + 2'd1;
    end
  end

  // word output; a trailing single byte is flushed at frame end, a lone nibble is dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      word_r       <= '0;
      word_valid_r <= 1'b0;
      frame_end_r  <= 1'b0;
    end else begin
      word_valid_r <= 1'b0;
      frame_end_r  <= end_stb;
      if (data_nib && nib_cnt_r == 2'd3) begin
        word_r.two_bytes <= 1'b1;
        // swap is meant to be static while traffic flows
        word_r.data      <= byte_swap ? {acc_r[7:0], sel_s.rxd, acc_r[11:8]}
                                      : {sel_s.rxd, acc_r[11:0]};
        word_valid_r     <= 1'b1;
      end else if (end_stb && nib_cnt_r[1]) begin
        word_r.two_bytes <= 1'b0;
        word_r.data      <= byte_swap ? {acc_r[7:0], 8'h00} : {8'h00, acc_r[7:0]};
        word_valid_r     <= 1'b1;
      end
    end
  end
  assign core_input_register = word_r;
  assign core_word_valid     = word_valid_r;
  assign frame_end           = frame_end_r;

  // preamble forwarding; the transmit side is trusted to drain before the next frame
  always_ff @(posedge clk) begin
    if (srst) begin
      fwd_r       <= '0;
      fwd_valid_r <= 1'b0;
    end else begin
      fwd_valid_r <= fwd_nib;
      if (fwd_nib) begin
        fwd_r.nibble <= sel_s.rxd;
        fwd_r.sfd    <= (sel_s.rxd == SFD_NIBBLE);
      end
    end
  end
  assign transmit_level1_fifo = fwd_r;
  assign fwd_valid            = fwd_valid_r;

  // buffer write pointer; restarts with each frame, stops when full to protect older words
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
    end else if (state_r == ST_IDLE && state_nxt != ST_IDLE && receive_buffer_en) begin
      wr_ptr_r <= '0;
    end else if (word_valid_r && receive_buffer_en && !wr_ptr_r[BUF_AW]) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end
  assign buf_fill = wr_ptr_r;

  // buffer storage: receive words when enabled, scratch writes only when disabled
  always_ff @(posedge clk) begin
    if (receive_buffer_en) begin
      if (word_valid_r && !wr_ptr_r[BUF_AW]) begin
        buf_mem[wr_ptr_r[BUF_AW-1:0]] <= word_r.data;
      end
    end else if (buf_wr) begin
      buf_mem[buf_addr] <= buf_wdata;
    end
  end

  // buffer read, one cycle latency
  always_ff @(posedge clk) begin
    if (srst) begin
      buf_rdata_r <= 16'h0000;
    end else begin
      buf_rdata_r <= buf_mem[buf_addr];
    end
  end
  assign buf_rdata = buf_rdata_r;

  // checks on the data path and registers
  reset_value_a: assert property (@(posedge clk) srst |=> receive_config_second_r == 32'h0000_0008)
    else $error("receive config reset value wrong");
  reserved_zero_a: assert property (@(posedge clk) disable iff (srst) (receive_config_second_r & 32'hffff_ff82) == 32'h0)
    else $error("receive config reserved bits not zero");
  tx_layout_a: assert property (@(posedge clk) disable iff (srst)
      reg_wr && reg_addr == TX_CFG1_OFFSET |=> transmit_config.start_delay == $past(reg_wdata[25:16])
      && transmit_config_first_r[4] && !transmit_config_first_r[31])
    else $error("transmit config layout wrong");
  port_select_a: assert property (@(posedge clk) disable iff (srst)
      sel_s.rx_dv == (receive_port_select ? port1_s.rx_dv : port0_s.rx_dv))
    else $error("wrong receive port selected");
  gate_off_a: assert property (@(posedge clk) disable iff (srst)
      !rx_enable |=> !fwd_valid_r && !(word_valid_r && word_r.two_bytes))
    else $error("traffic passed while disabled");
  no_strip_pass_a: assert property (@(posedge clk) disable iff (srst)
      state_r == ST_IDLE && nib_stb && sel_s.rx_dv && !preamble_strip && !preamble_forward_en
      |=> state_r == ST_DATA && nib_cnt_r == 2'd1)
    else $error("first nibble not passed through");
  strip_drop_a: assert property (@(posedge clk) disable iff (srst)
      state_r == ST_PREAMBLE && $past(state_r) == ST_PREAMBLE |-> nib_cnt_r == 2'd0)
    else $error("preamble nibble reached the word");
  sfd_to_data_a: assert property (@(posedge clk) disable iff (srst)
      state_r == ST_PREAMBLE && nib_stb && sel_s.rx_dv && sel_s.rxd == SFD_NIBBLE
      |=> state_r == ST_DATA && nib_cnt_r == 2'd0)
    else $error("sfd did not open the data phase");
  fwd_nibble_a: assert property (@(posedge clk) disable iff (srst)
      fwd_nib |=> fwd_valid_r && fwd_r.nibble == $past(sel_s.rxd))
    else $error("preamble nibble not forwarded");
  swap_order_a: assert property (@(posedge clk) disable iff (srst)
      data_nib && nib_cnt_r == 2'd3 && !byte_swap |=> word_valid_r && word_r.data[3:0] == $past(acc_r[3:0]))
    else $error("byte order wrong without swap");
  buf_gate_a: assert property (@(posedge clk) disable iff (srst)
      !receive_buffer_en && !$past(receive_buffer_en) |-> $stable(wr_ptr_r))
    else $error("buffer fed while disabled");

endmodule : mii_receive_port_config

`default_nettype wire

/* mii_phy_model.sv */
// behavioural phy on one mii receive port, nibble clock runs only inside frames
// assumes the bench calls send for one whole frame at a time
`default_nettype none

module mii_phy_model
  import mii_rx_pkg::*;
(
  // pins toward the receive port
  output var mii_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: clock low, no data valid
  initial pins = '0;

  // one frame, nibble0 first; 400 ns nibble period stays under clk/8
  task automatic send(input logic [3:0] nib[$]);
    foreach (nib[i]) begin
      pins.rx_clk = 1'b0;
      pins.rx_dv  = 1'b1;
      pins.rxd    = nib[i];
      #200 pins.rx_clk = 1'b1;
      #200;
    end
    // one edge with dv low closes the frame; old data is not left on the wire
    pins.rx_clk = 1'b0;
    pins.rx_dv  = 1'b0;
    pins.rxd    = ~pins.rxd;
    #200 pins.rx_clk = 1'b1;
    #200 pins.rx_clk = 1'b0;
  endtask : send
endmodule : mii_phy_model

`default_nettype wire

/* mii_receive_port_config_bench.sv */
// self-checking bench for the second mii receive channel with two phy models
// assumes a 25 MHz clk and the phy nibble clock well below clk/8
`default_nettype none

module mii_receive_port_config_bench
  import mii_rx_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic           clk;
  logic           srst;
  logic [7:0]     reg_addr;
  logic           reg_wr;
  logic [31:0]    reg_wdata;
  logic [31:0]    reg_rdata;
  mii_pins_type   p0;
  mii_pins_type   p1;
  rx_word_type    core_w;
  logic           core_v;
  logic           f_end;
  logic           f_act;
  fwd_nibble_type fwd_n;
  logic           fwd_v;
  logic [5:0]     buf_addr;
  logic           buf_wr;
  logic [15:0]    buf_wdata;
  logic [15:0]    buf_rdata;
  logic [6:0]     buf_fill;
  tx_cfg_type     tx_cfg;
  int             err_total;
  int             tests_run;
  int             ends;
  int             n_words;
  logic [15:0]    first_word;
  logic [31:0]    v;
  logic [16:0]    m;
  bit             swap_now;
  logic [16:0]    exp_w[$];
  logic [4:0]     exp_f[$];

  mii_receive_port_config #(.BUF_DEPTH(64)) u_mii_receive_port_config (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .mii_port0(p0), .mii_port1(p1), .core_input_register(core_w),
    .core_word_valid(core_v), .frame_end(f_end), .frame_active(f_act),
    .transmit_level1_fifo(fwd_n), .fwd_valid(fwd_v), .buf_addr(buf_addr), .buf_wr(buf_wr),
    .buf_wdata(buf_wdata), .buf_rdata(buf_rdata), .buf_fill(buf_fill), .transmit_config(tx_cfg));
  mii_phy_model u_phy0 (.pins(p0));
  mii_phy_model u_phy1 (.pins(p1));

  // free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // compare every word and forwarded nibble against the model queues
  always @(posedge clk) begin
    if (!srst && core_v) begin
      m = core_w.two_bytes ? 17'h1ffff : (swap_now ? 17'h1fe01 : 17'h001ff);
      if (exp_w.size() == 0) check(32'h0, 32'h1);
      else check({15'h0, core_w & m}, {15'h0, exp_w.pop_front()});
    end
    if (!srst && fwd_v) begin
      if (exp_f.size() == 0) check(32'h0, 32'h2);
      else check({27'h0, fwd_n}, {27'h0, exp_f.pop_front()});
    end
    if (!srst && f_end) ends++;
  end

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  endtask : reg_read

  // reference model: preamble handling, then bytes paired into words
  task automatic build(input logic [3:0] nib[$], input bit cut, input bit fwd, input bit swp);
    int         k;
    logic [7:0] b[$];
    k = 0;
    if (cut || fwd) begin
      while (nib[k] != SFD_NIBBLE) begin
        if (fwd) exp_f.push_back({nib[k], 1'b0});
        k++;
      end
      if (fwd) exp_f.push_back({nib[k], 1'b1});
      k++;
    end
    // nibble0 of each byte is the earlier one on the wire
    while (k + 1 < nib.size()) begin
      b.push_back({nib[k+1], nib[k]});
      k += 2;
    end
    for (k = 0; k + 1 < b.size(); k += 2)
      exp_w.push_back(swp ? {b[k], b[k+1], 1'b1} : {b[k+1], b[k], 1'b1});
    if (k < b.size()) exp_w.push_back(swp ? {b[k], 8'h00, 1'b0} : {8'h00, b[k], 1'b0});
    n_words    = exp_w.size();
    first_word = exp_w[0][16:1];
  endtask : build

  // one frame on the chosen phy; live says whether output is expected
  task automatic run_frame(input logic [31:0] cfg, input bit on1, input bit live);
    logic [3:0] q[$];
    int         e0;
    int         t;
    // written only between frames, so swap never changes under traffic
    reg_write(RX_CFG2_OFFSET, cfg);
    repeat (cfg[6] ? 2 : 15) q.push_back(4'h5);
    q.push_back(SFD_NIBBLE);
    repeat (10) q.push_back(4'($urandom));
    swap_now = cfg[5];
    if (live) build(q, cfg[2], cfg[6], cfg[5]);
    e0 = ends;
    if (on1) u_phy1.send(q);
    else u_phy0.send(q);
    t = 0;
    while (live && ends == e0 && t < 200) begin
      @(negedge clk);
      t++;
    end
    if (t == 200) begin
      check(32'h0, 32'h3);
      finish_test();
    end
    repeat (live ? 2 : 30) @(negedge clk);
    check(exp_w.size() + exp_f.size(), 32'h0);
    check({31'h0, f_act}, 32'h0);
  endtask : run_frame

  // main sequence
  initial begin
    srst      = 1'b1;
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 32'h0;
    buf_addr  = 6'h00;
    buf_wr    = 1'b0;
    buf_wdata = 16'h0;
    err_total = 0;
    tests_run = 0;
    ends      = 0;
    swap_now  = 1'b0;
    void'($urandom(21372));
    repeat (6) @(negedge clk);
    srst = 1'b0;
    reg_read(RX_CFG2_OFFSET, v);
    check(v, 32'h0000_0008);
    reg_read(TX_CFG1_OFFSET, v);
    check(v, 32'h0002_0010);
    reg_read(8'h08, v);
    check(v, 32'h0);
    reg_write(TX_CFG1_OFFSET, 32'hffff_ffff);
    reg_read(TX_CFG1_OFFSET, v);
    check(v, 32'h73ff_031f);
    check({13'h0, tx_cfg}, 32'h0007_ffff);
    // auto sequence and auto preamble off before swap or forwarding is used
    reg_write(TX_CFG1_OFFSET, 32'h0);
    reg_read(TX_CFG1_OFFSET, v);
    check(v, 32'h0000_0010);
    // forwarding left clear while stripping is set
    reg_write(RX_CFG2_OFFSET, 32'hffff_ffbf);
    reg_read(RX_CFG2_OFFSET, v);
    check(v, 32'h0000_003d);
    run_frame(32'h09, 1'b1, 1'b1);
    run_frame(32'h0d, 1'b1, 1'b1);
    run_frame(32'h49, 1'b1, 1'b1);
    run_frame(32'h35, 1'b0, 1'b1);
    check({25'h0, buf_fill}, n_words);
    @(negedge clk);
    buf_addr = 6'h00;
    @(negedge clk);
    check({16'h0, buf_rdata}, {16'h0, first_word});
    run_frame(32'h09, 1'b0, 1'b0);
    run_frame(32'h08, 1'b1, 1'b0);
    // buffer enable now clear: scratch-pad write and read back
    @(negedge clk);
    buf_addr  = 6'h09;
    buf_wdata = 16'($urandom);
    buf_wr    = 1'b1;
    @(negedge clk);
    buf_wr    = 1'b0;
    @(negedge clk);
    check({16'h0, buf_rdata}, {16'h0, buf_wdata});
    finish_test();
  end
endmodule : mii_receive_port_config_bench

`default_nettype wire
